// ---- design/egt_divider.sv ----
// Odd clock divider acting on oscillator ticks ahead of the prescaler.
`timescale 1ns/1ps
module egt_divider
	import egt_pkg::*;
(
	// Clock, reset and enable.
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	// Oscillator ticks in, divider code, guard clock ticks out.
	input wire logic tick_in,
	input wire logic [2:0] code_in,
	output logic tick_out
);

	egt_div_s st;
	egt_div_s next_st;
	logic [2:0] factor;
	logic [2:0] cnt_inc;

	assign factor = egt_div_factor(code_in);
	assign cnt_inc = 3'(st.cnt + 3'h1);

	// Every factor-th oscillator tick becomes one guard tick.
	always_comb begin
		next_st = st;
		if (ce_in) begin
			next_st.tick = 1'b0;
			if (tick_in) begin
				if (cnt_inc >= factor) begin
					next_st.cnt = 3'h0;
					next_st.tick = 1'b1;
				end else begin
					next_st.cnt = cnt_inc;
				end
			end
		end
	end

	// State register.
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick_out = st.tick;

	// A guard tick only ever follows an oscillator tick.
	chk_div_tick: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		$rose(st.tick) |-> $past(tick_in))
		else $error("Divider ticked without an oscillator tick.");

endmodule

// ---- design/egt_pkg.sv ----
// Shared constants, register layouts and state types of the enhanced guard timer.
package egt_pkg;

	// ************************************************************
	// Timing figures
	// ************************************************************
	// Rate of the dedicated guard oscillator and of the system clock.
	localparam int unsigned OSC_FREQ_HZ = 128000;
	localparam int unsigned SYS_CLK_HZ = 125000000;
	// Width of the change window, in system clock cycles.
	localparam logic [2:0] CHG_WINDOW_CYCLES = 3'h4;
	// Shortest timeout, in guard clock cycles, selected by prescaler code zero.
	localparam logic [21:0] TMO_BASE_CYCLES = 22'h000800;
	// Highest legal prescaler code; larger codes saturate here.
	localparam logic [3:0] TMO_CODE_MAX = 4'h9;
	// Prescaler code and figure of the half-second timeout.
	localparam logic [3:0] TMO_CODE_64K = 4'h5;
	localparam logic [21:0] TMO_64K_CYCLES = 22'h010000;

	// ************************************************************
	// Register layouts, most significant field first
	// ************************************************************
	// Guard control register.
	typedef struct packed {
		logic dflag;
		logic ie;
		logic wdp_hi;
		logic chg;
		logic re;
		logic [2:0] wdp_lo;
	} egt_ctrl_reg_s;

	// Odd divider register.
	typedef struct packed {
		logic [1:0] rsvd;
		logic ew_clr_mode;
		logic div_hi;
		logic ew_flag;
		logic ew_en;
		logic [1:0] div_lo;
	} egt_div_reg_s;

	// Write strobes travel with their data.
	typedef struct packed {
		logic wr;
		egt_ctrl_reg_s data;
	} egt_ctrl_wr_s;

	typedef struct packed {
		logic wr;
		egt_div_reg_s data;
	} egt_div_wr_s;

	// Reset values of the two registers.
	localparam egt_ctrl_reg_s CTRL_RST = 8'h00;
	localparam egt_div_reg_s DIV_RST = 8'h00;

	// ************************************************************
	// State of each module
	// ************************************************************
	typedef struct packed {
		logic stage1;
		logic stage2;
	} egt_sync_s;

	typedef struct packed {
		logic [2:0] cnt;
		logic tick;
	} egt_div_s;

	typedef struct packed {
		logic osc_prev;
		logic ie;
		logic re;
		logic chg;
		logic [2:0] win;
		logic [3:0] timeout_prescaler_field;
		logic [2:0] div_code;
		logic ew_en;
		logic ew_flag;
		logic ew_clr_mode;
		logic dflag;
		logic half;
		logic [21:0] count;
		logic rst;
	} egt_state_s;

	localparam egt_state_s STATE_RST = '0;

	// Odd division factor for a divider code; reserved codes divide by one.
	function automatic logic [2:0] egt_div_factor(input logic [2:0] code);
		logic [2:0] f;
		f = 3'h1;
		unique case (code)
			3'h1: f = 3'h3;
			3'h2: f = 3'h5;
			3'h3: f = 3'h7;
			default: f = 3'h1;
		endcase
		return f;
	endfunction

endpackage

// ---- design/egt_sync.sv ----
// Two-stage synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ps
module egt_sync
	import egt_pkg::*;
(
	// Clock, reset and enable.
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	// Asynchronous level and its synchronised copy.
	input wire logic async_in,
	output logic sync_out
);

	egt_sync_s st;
	egt_sync_s next_st;

	// The first stage feeds only the second, to let metastability settle.
	always_comb begin
		next_st = st;
		if (ce_in) begin
			next_st.stage1 = async_in;
			next_st.stage2 = st.stage1;
		end
	end

	// State register.
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sync_out = st.stage2;

endmodule

// ---- design/egt_top.sv ----
// Enhanced guard timer: counter, modes, timed change window and register ports.
// What this block does
// - Counter advances on ticks of a separate 128 kHz oscillator, not system clock.
// - With early warning enabled, first timeout sets the early warning flag.
// - At twice the timeout, raise interrupt or system reset per mode.
// - Interrupt-only mode flags an interrupt at double expiry, usable as wake.
// - Reset-only mode issues a system reset at double expiry.
// - Combined mode interrupts first, then later double expiry resets.
// - Always-on fuse forces reset enable high and interrupt enable low.
// - Reset-enable clear or prescaler change accepted only inside the window.
// - Prescaler divides by powers of two only.
// - Odd divider by 3, 5 or 7 acts before the prescaler.
// - Divider loads only inside the window; reset enable ends set.
// - A guard-caused reset leaves the guard enabled afterwards.
// - Prescaler code 0101 selects 64K guard cycles, about half a second.
// - Change enable self-clears four clock cycles after being set.
// - While the reset flag is set, reset enable stays forced to one.
// - Double expiry flag clears on vector execution or written one.
// - In combined mode, the vector clears interrupt enable and the flag.
`timescale 1ns/1ps
module egt_top
	import egt_pkg::*;
#(
	parameter logic [21:0] TMO_BASE = TMO_BASE_CYCLES
) (
	// Clock, reset and enable.
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	// Dedicated oscillator, asynchronous to the system clock.
	input wire logic osc_128k_in,
	// Core events.
	input wire logic restart_in,
	input wire logic vector_ack_in,
	// Register writes and readback.
	input wire egt_ctrl_wr_s ctrl_write_in,
	input wire egt_div_wr_s div_write_in,
	output egt_ctrl_reg_s ctrl_rdata_out,
	output egt_div_reg_s div_rdata_out,
	// Reset cause and fuse levels.
	input wire logic guard_reset_flag_in,
	input wire logic guard_always_on_fuse_in,
	// Interrupt request and system reset.
	output logic irq_out,
	output logic sys_reset_out
);

	// ************************************************************
	// Oscillator tick path
	// ************************************************************
	egt_state_s st;
	egt_state_s next_st;
	logic osc_sync;
	logic osc_rise;
	logic wd_tick;

	egt_sync u_osc_sync (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.async_in(osc_128k_in),
		.sync_out(osc_sync)
	);

	// Only the synchronised copy is edge-detected.
	assign osc_rise = osc_sync & ~st.osc_prev;

	egt_divider u_divider (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.tick_in(osc_rise),
		.code_in(st.div_code),
		.tick_out(wd_tick)
	);

	// ************************************************************
	// Mode decode and expiry detection
	// ************************************************************
	logic fuse;
	logic ie_eff;
	logic re_eff;
	logic active;
	logic [3:0] wdp_sat;
	logic [21:0] tmo;
	logic [21:0] tmo2;
	logic [21:0] count_inc;
	logic first_hit;
	logic second_hit;
	logic open_req;
	logic update_req;
	logic dflag_set;
	logic dflag_clr;
	logic ew_set;
	logic ew_clr;
	logic reset_fire;

	assign fuse = guard_always_on_fuse_in;
	// The fuse locks the mode bits whatever software wrote.
	assign ie_eff = st.ie & ~fuse;
	assign re_eff = st.re | fuse | guard_reset_flag_in;
	assign active = ie_eff | re_eff;

	// Power-of-two prescaler; reserved codes saturate at the longest timeout.
	assign wdp_sat = (st.timeout_prescaler_field > TMO_CODE_MAX) ? TMO_CODE_MAX : st.timeout_prescaler_field;
	assign tmo = TMO_BASE << wdp_sat;
	assign tmo2 = {tmo[20:0], 1'b0};
	assign count_inc = 22'(st.count + 22'h1);

	// A restart in the same cycle beats any expiry.
	assign first_hit = wd_tick & active & ~restart_in & ~st.half & (count_inc >= tmo);
	assign second_hit = wd_tick & active & ~restart_in & (count_inc >= tmo2);

	// Timed sequence decode.
	assign open_req = ctrl_write_in.wr & ctrl_write_in.data.chg & ctrl_write_in.data.re;
	assign update_req = ctrl_write_in.wr & st.chg & ~ctrl_write_in.data.chg;

	// Double expiry outcome per mode: a pending interrupt in combined mode means reset.
	assign dflag_set = second_hit & ie_eff & ~(re_eff & st.dflag);
	assign reset_fire = second_hit & re_eff & (~ie_eff | st.dflag);
	assign dflag_clr = (ctrl_write_in.wr & ctrl_write_in.data.dflag) | vector_ack_in;
	assign ew_set = first_hit & st.ew_en;
	assign ew_clr = (div_write_in.wr & div_write_in.data.ew_flag)
		| (vector_ack_in & ~st.ew_clr_mode);

	// ************************************************************
	// Next-state logic
	// ************************************************************
	// All state freezes while the clock enable is low.
	always_comb begin
		next_st = st;
		if (ce_in) begin
			next_st.osc_prev = osc_sync;
			next_st.rst = reset_fire;
			// The window counts down and closes itself.
			if (st.chg) begin
				if (st.win == 3'h1) begin
					next_st.chg = 1'b0;
					next_st.win = 3'h0;
				end else begin
					next_st.win = 3'(st.win - 3'h1);
				end
			end
			// Control writes: setting reset enable is always allowed, clearing is not.
			if (ctrl_write_in.wr) begin
				next_st.ie = ctrl_write_in.data.ie;
				if (ctrl_write_in.data.re) begin
					next_st.re = 1'b1;
				end
				if (update_req) begin
					next_st.re = ctrl_write_in.data.re;
					next_st.timeout_prescaler_field = {ctrl_write_in.data.wdp_hi, ctrl_write_in.data.wdp_lo};
				end
				if (open_req) begin
					next_st.chg = 1'b1;
					next_st.win = CHG_WINDOW_CYCLES;
				end
			end
			// Divider writes: the code is protected, the early warning bits are not.
			if (div_write_in.wr) begin
				next_st.ew_en = div_write_in.data.ew_en;
				next_st.ew_clr_mode = div_write_in.data.ew_clr_mode;
				if (st.chg) begin
					next_st.div_code = {div_write_in.data.div_hi, div_write_in.data.div_lo};
					next_st.re = 1'b1;
				end
			end
			// The vector leaves combined mode for reset-only mode.
			if (vector_ack_in & ie_eff & re_eff) begin
				next_st.ie = 1'b0;
			end
			// Fuse and reset flag override whatever was written.
			if (fuse) begin
				next_st.ie = 1'b0;
			end
			if (fuse | guard_reset_flag_in) begin
				next_st.re = 1'b1;
			end
			// Counter: restart or a stopped guard holds it at zero.
			if (restart_in | ~active) begin
				next_st.count = 22'h0;
				next_st.half = 1'b0;
			end else if (wd_tick) begin
				if (second_hit) begin
					next_st.count = 22'h0;
					next_st.half = 1'b0;
				end else begin
					next_st.count = count_inc;
					if (first_hit) begin
						next_st.half = 1'b1;
					end
				end
			end
			// Hardware sets win over software or vector clears.
			next_st.dflag = dflag_set | (st.dflag & ~dflag_clr);
			next_st.ew_flag = ew_set | (st.ew_flag & ~ew_clr);
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st <= STATE_RST;
		end else begin
			st <= next_st;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// Readback comes straight from the flops; reserved bits read zero.
	always_comb begin
		ctrl_rdata_out = CTRL_RST;
		ctrl_rdata_out.dflag = st.dflag;
		ctrl_rdata_out.ie = st.ie;
		ctrl_rdata_out.wdp_hi = st.timeout_prescaler_field[3];
		ctrl_rdata_out.chg = st.chg;
		ctrl_rdata_out.re = st.re;
		ctrl_rdata_out.wdp_lo = st.timeout_prescaler_field[2:0];
		div_rdata_out = DIV_RST;
		div_rdata_out.ew_clr_mode = st.ew_clr_mode;
		div_rdata_out.div_hi = st.div_code[2];
		div_rdata_out.ew_flag = st.ew_flag;
		div_rdata_out.ew_en = st.ew_en;
		div_rdata_out.div_lo = st.div_code[1:0];
	end

	// The request stays up while a flag is pending, so it also serves as wake-up.
	assign irq_out = (st.dflag & ie_eff) | (st.ew_flag & st.ew_en);
	assign sys_reset_out = st.rst;

	// ************************************************************
	// Checks
	// ************************************************************
	// Four idle cycles after an open must leave the window shut again.
	chk_window_self_close: assert property (@(posedge sys_clk_in)
		disable iff (!reset_n_in)
		(ce_in && open_req) ##1 (ce_in && !ctrl_write_in.wr)[*4] |=> !st.chg)
		else $error("Change window did not close after four cycles.");

	// Runaway code writing a zero must not stop a running guard.
	chk_reenable_guarded: assert property (@(posedge sys_clk_in)
		disable iff (!reset_n_in)
		(ce_in && ctrl_write_in.wr && !st.chg && st.re && !ctrl_write_in.data.re)
		|=> st.re)
		else $error("Reset enable cleared outside the change window.");

	// A shorter timeout slipped in outside the window could fire unexpectedly.
	chk_prescaler_guarded: assert property (@(posedge sys_clk_in)
		disable iff (!reset_n_in)
		(ce_in && !st.chg) |=> st.timeout_prescaler_field == $past(st.timeout_prescaler_field))
		else $error("Prescaler changed outside the change window.");

	// The flag keeps repeated resets coming until software has seen it.
	chk_flag_forces_re: assert property (@(posedge sys_clk_in)
		disable iff (!reset_n_in)
		(ce_in && guard_reset_flag_in) |=> st.re)
		else $error("Reset flag did not force reset enable.");

	// With the fuse programmed nothing but a reset may follow a double expiry.
	chk_fuse_resets: assert property (@(posedge sys_clk_in)
		disable iff (!reset_n_in)
		(ce_in && fuse && second_hit) |=> sys_reset_out && !st.ie)
		else $error("Fused guard did not reset at double expiry.");

	// The warning must not restart the count, or the reset would never come.
	chk_early_warning: assert property (@(posedge sys_clk_in)
		disable iff (!reset_n_in)
		(ce_in && first_hit && st.ew_en) |=> st.ew_flag && st.half)
		else $error("Early warning not raised at first expiry.");

	// Interrupt-only mode may wake the core but never reset it.
	chk_int_only_mode: assert property (@(posedge sys_clk_in)
		disable iff (!reset_n_in)
		(ce_in && second_hit && ie_eff && !re_eff) |=> st.dflag && irq_out && !sys_reset_out)
		else $error("Interrupt-only mode misbehaved at double expiry.");

	// The reset request is a single-cycle pulse from a flop.
	chk_reset_pulse: assert property (@(posedge sys_clk_in)
		disable iff (!reset_n_in)
		(ce_in && second_hit && re_eff && !ie_eff) |=> sys_reset_out ##1 !sys_reset_out)
		else $error("Reset-only mode did not give a one-cycle reset.");

	// Serving the vector hands the guard back to plain reset mode.
	chk_combined_vector: assert property (@(posedge sys_clk_in)
		disable iff (!reset_n_in)
		(ce_in && vector_ack_in && ie_eff && re_eff && !second_hit) |=> !st.ie && !st.dflag)
		else $error("Combined mode vector did not return to reset-only mode.");

	// A restart in the expiry cycle must win over the reset.
	chk_restart_zero: assert property (@(posedge sys_clk_in)
		disable iff (!reset_n_in)
		(ce_in && restart_in) |=> st.count == 22'h0 && !sys_reset_out)
		else $error("Restart did not zero the counter.");

	// Code five scales the base by the 64K ratio, so the default base gives 64K cycles.
	chk_half_second: assert property (@(posedge sys_clk_in)
		disable iff (!reset_n_in)
		(st.timeout_prescaler_field == TMO_CODE_64K) |-> tmo == 22'(TMO_BASE * (TMO_64K_CYCLES / TMO_BASE_CYCLES)))
		else $error("Prescaler code five does not select 64K cycles.");

endmodule

// ---- verif/egt_core_model.sv ----
// Core-side model of the guard timer: free-running oscillator and vector service.
`timescale 1ns/1ps
module egt_core_model
	import egt_pkg::*;
#(
	parameter int OSC_HALF_NS = 40
) (
	// Clock and service enable.
	input wire logic sys_clk_in,
	input wire logic ack_en_in,
	// Interrupt request in, oscillator and vector strobe out.
	input wire logic irq_in,
	output logic osc_out,
	output logic vector_ack_out
);
	logic [1:0] wait_cnt = 2'h0;

	// The oscillator runs free; the odd start offset keeps its edges off the clock edges.
	initial begin
		osc_out = 1'b0;
		#3;
		forever #(OSC_HALF_NS) osc_out = ~osc_out;
	end

	// A serving core enters the vector a few cycles after the request, for one cycle.
	always @(posedge sys_clk_in) begin
		vector_ack_out <= 1'b0;
		if (ack_en_in && irq_in === 1'b1 && !vector_ack_out) begin
			wait_cnt <= wait_cnt + 2'h1;
			if (wait_cnt == 2'h3) begin
				vector_ack_out <= 1'b1;
			end
		end else begin
			wait_cnt <= 2'h0;
		end
	end
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench of the enhanced guard timer.
`timescale 1ns/1ps
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
	$display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module testbench
	import egt_pkg::*;
;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic restart = 1'b0;
	logic fuse = 1'b0;
	logic rflag = 1'b0;
	logic ack_en = 1'b0;
	egt_ctrl_wr_s ctrl_w = '0;
	egt_div_wr_s div_w = '0;
	egt_ctrl_reg_s ctrl_rd;
	egt_div_reg_s div_rd;
	logic osc, vack, irq, sys_rst;
	int error_cnt = 0;
	int num_checks = 0;
	int rst_seen = 0;
	int cyc = 0;
	int n, m;

	// One oscillator tick is ten clocks, so a timeout of four ticks is forty clocks.
	always #4 sys_clk = ~sys_clk;

	egt_top #(.TMO_BASE(22'h000004)) i_egt_top (
		.sys_clk_in(sys_clk), .reset_n_in(reset_n), .ce_in(1'b1), .osc_128k_in(osc),
		.restart_in(restart), .vector_ack_in(vack), .ctrl_write_in(ctrl_w),
		.div_write_in(div_w), .ctrl_rdata_out(ctrl_rd), .div_rdata_out(div_rd),
		.guard_reset_flag_in(rflag), .guard_always_on_fuse_in(fuse),
		.irq_out(irq), .sys_reset_out(sys_rst));

	egt_core_model i_egt_core_model (
		.sys_clk_in(sys_clk), .ack_en_in(ack_en), .irq_in(irq),
		.osc_out(osc), .vector_ack_out(vack));

	// Cycle budget and tally of reset pulses; running out counts as a mismatch.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (sys_rst === 1'b1) begin
			rst_seen <= rst_seen + 1;
		end
		if (cyc == 30000) begin
			error_cnt++;
			stop_test();
		end
	end

	// ************************************************************
	// Access tasks
	// ************************************************************
	// One register write: strobe for one cycle, taken at the following edge.
	task automatic wr(input logic sel, input logic [7:0] d);
		@(posedge sys_clk);
		if (sel) begin
			div_w <= {1'b1, d};
		end else begin
			ctrl_w <= {1'b1, d};
		end
		@(posedge sys_clk);
		div_w <= '0;
		ctrl_w <= '0;
	endtask

	// Timed change; no vector is served meanwhile, so the four-cycle window is never missed.
	// The opening write keeps prescaler and interrupt enable as they are.
	task automatic change(input logic [7:0] d);
		logic keep;
		keep = ack_en;
		ack_en <= 1'b0;
		wr(1'b0, 8'h18 | (ctrl_rd & 8'h67));
		wr(1'b0, d);
		ack_en <= keep;
	endtask

	task automatic idle(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask

	task automatic kick();
		@(posedge sys_clk);
		restart <= 1'b1;
		@(posedge sys_clk);
		restart <= 1'b0;
	endtask

	// Counts clocks until the interrupt (sel 0) or reset pulse (sel 1) shows, up to lim.
	task automatic wait_out(input logic sel, input int lim);
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (((sel ? sys_rst : irq) !== 1'b1) && n < lim);
	endtask

	task automatic fin(input string s);
		$display("%s finished, %0d checks so far", s, num_checks);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ************************************************************
	// Test sequence
	// ************************************************************
	initial begin
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		idle(200);
		`CHECK(ctrl_rd, 8'h00)
		`CHECK(div_rd, 8'h00)
		`CHECK(rst_seen, 0)
		`CHECK(irq, 1'b0)
		fin("reset and stopped");
		// Window: setting reset enable always taken, clearing it and prescaler only inside the window.
		wr(1'b0, 8'h08);
		idle(2);
		`CHECK(ctrl_rd, 8'h08)
		change(8'h0D);
		idle(1);
		`CHECK(ctrl_rd, 8'h1D)
		idle(3);
		`CHECK(ctrl_rd, 8'h0D)
		wr(1'b0, 8'h1F);
		idle(6);
		`CHECK(ctrl_rd, 8'h0D)
		wr(1'b0, 8'h00);
		idle(2);
		`CHECK(ctrl_rd, 8'h0D)
		fin("change window");
		// Early warning at one timeout, reset at two, for three prescaler codes.
		wr(1'b1, 8'h04);
		for (int w = 0; w < 3; w++) begin
			kick();
			change(8'h08 | w[7:0]);
			wr(1'b1, 8'h0C);
			kick();
			wait_out(1'b0, 2000);
			m = n;
			`CHECK(n inside {[(40 << w) - 9 : (40 << w) + 9]}, 1'b1)
			wait_out(1'b1, 2000);
			`CHECK((m + n) inside {[(80 << w) - 9 : (80 << w) + 9]}, 1'b1)
			idle(1);
			`CHECK(sys_rst, 1'b0)
		end
		fin("timeouts");
		// Regular restarts keep the reset away.
		change(8'h08);
		wr(1'b1, 8'h08);
		kick();
		m = rst_seen;
		repeat (8) begin
			idle(50);
			kick();
		end
		`CHECK(rst_seen, m)
		fin("restart");
		// Divide by seven; codes refused once the window has closed.
		wr(1'b0, 8'h18 | (ctrl_rd & 8'h67));
		wr(1'b1, 8'h03);
		idle(4);
		`CHECK(div_rd, 8'h03)
		`CHECK(ctrl_rd.re, 1'b1)
		wr(1'b1, 8'hC1);
		idle(2);
		`CHECK(div_rd, 8'h03)
		kick();
		wait_out(1'b1, 800);
		`CHECK(n inside {[490:569]}, 1'b1)
		wr(1'b0, 8'h18 | (ctrl_rd & 8'h67));
		wr(1'b1, 8'h00);
		idle(2);
		fin("odd divider");
		// Interrupt-only mode, flag cleared by writing one and by the vector.
		change(8'h40);
		idle(2);
		`CHECK(ctrl_rd, 8'h40)
		kick();
		m = rst_seen;
		wait_out(1'b0, 200);
		`CHECK(n inside {[71:89]}, 1'b1)
		idle(1);
		`CHECK(ctrl_rd, 8'hC0)
		wr(1'b0, 8'hC0);
		idle(2);
		`CHECK(ctrl_rd, 8'h40)
		@(posedge sys_clk);
		ack_en <= 1'b1;
		kick();
		wait_out(1'b0, 200);
		idle(8);
		`CHECK(ctrl_rd, 8'h40)
		`CHECK(irq, 1'b0)
		`CHECK(rst_seen, m)
		fin("interrupt mode");
		// Combined mode: interrupt, vector drops to reset mode, then a reset.
		wr(1'b0, 8'h48);
		kick();
		m = rst_seen;
		wait_out(1'b0, 200);
		`CHECK(n inside {[71:89]}, 1'b1)
		idle(8);
		`CHECK(ctrl_rd, 8'h08)
		`CHECK(rst_seen, m)
		@(posedge sys_clk);
		ack_en <= 1'b0;
		wait_out(1'b1, 200);
		`CHECK(n inside {[55:90]}, 1'b1)
		fin("combined mode");
		// Early warning survives the vector in flag clear mode; a written one clears it.
		wr(1'b1, 8'h24);
		@(posedge sys_clk);
		ack_en <= 1'b1;
		kick();
		wait_out(1'b0, 200);
		`CHECK(n inside {[31:49]}, 1'b1)
		idle(8);
		`CHECK(div_rd, 8'h2C)
		wr(1'b1, 8'h2C);
		idle(2);
		`CHECK(div_rd, 8'h24)
		@(posedge sys_clk);
		ack_en <= 1'b0;
		wr(1'b1, 8'h08);
		fin("early warning hold");
		// Fuse and reset flag hold the reset enable.
		@(posedge sys_clk);
		fuse <= 1'b1;
		change(8'h40);
		idle(2);
		`CHECK(ctrl_rd, 8'h08)
		kick();
		wait_out(1'b1, 200);
		`CHECK(n inside {[71:89]}, 1'b1)
		`CHECK(irq, 1'b0)
		@(posedge sys_clk);
		fuse <= 1'b0;
		rflag <= 1'b1;
		change(8'h00);
		idle(2);
		`CHECK(ctrl_rd, 8'h08)
		@(posedge sys_clk);
		rflag <= 1'b0;
		change(8'h00);
		idle(2);
		`CHECK(ctrl_rd, 8'h00)
		m = rst_seen;
		idle(200);
		`CHECK(rst_seen, m)
		fin("fuse and flag");
		stop_test();
	end
endmodule
